/* File: rtl/identify_data_composer.sv */
/*
 * identify_data_composer: builds the 256-word identification page into a
 * sector buffer on command, then hands it word by word to the host data port.
 * assumes: all inputs synchronous to core_clk; host reads only while drq is high.
 */
// Summary of operation
// - command: busy, fill page, drq, interrupt, read
// - word 0 reports ata fixed device
// - serial in words 10-19, right justified
// - firmware in words 23-26, left justified
// - model in words 27-46, left justified, blank padded
// - capabilities word: iordy, lba, dma bits
// - word 51 high byte reports pio mode 2
// - word 53 marks three groups valid
// - word 59 multiple enable and sector count
// - word 63 mwdma mode in use, supported
// - word 64 flags pio modes 3, 4
// - word 80 flags ata-1 through ata-4
// - word 82 fixed command set support bits
// - word 83 bit 14, apm support
// - word 85 look-ahead, cache, smart enabled
// - word 86 apm enabled
// - word 88 udma in use and supported
// - word 93 bit 13 from cable detect
module identify_data_composer (
   input  wire logic        core_clk,   // 200 MHz clock
   input  wire logic        rst,        // async reset, active high
   input  wire logic [7:0]  reg_addr,   // register byte address
   input  wire logic [31:0] reg_wdata,  // register write data
   input  wire logic        reg_wr,     // write strobe
   input  wire logic        reg_rd,     // read strobe
   output logic      [31:0] reg_rdata,  // read data, cycle after strobe
   input  wire logic        ident_cmd,  // identification command pulse
   input  wire logic        cable_det,  // cable-detect level
   input  wire logic        host_rd,    // host data read pulse
   output logic      [15:0] host_data,  // page word, cycle after read
   output logic             busy,       // page being composed
   output logic             drq,        // page ready for host
   output logic             intrq       // interrupt request level
);

   ////////////////////////////////////////////////////////////////////////////
   // state and storage
   typedef enum logic [1:0] {IDLE, FILL, SEND} phase_t;

   phase_t      phase_q;                           // command phase
   logic [7:0]  text_q [identify_pkg::TEXT_CHARS];  // raw string characters
   logic [15:0] page_q [identify_pkg::PAGE_WORDS];  // sector buffer
   logic [7:0]  fill_idx_q;                        // word being composed
   logic [7:0]  rd_idx_q;                          // next word for host
   logic        multi_en_q;                        // multiple transfer enabled
   logic [7:0]  multi_cnt_q;                       // sectors per block
   logic [7:0]  mwdma_cur_q;                       // mwdma mode in use
   logic [4:0]  udma_cur_q;                        // udma mode in use
   logic [4:0]  ser_len_q;                         // serial length
   logic [3:0]  fw_len_q;                          // firmware length
   logic [5:0]  model_len_q;                       // model length
   logic        cable_q;                           // cable level taken at command
   logic [15:0] word_d;                            // composed word
   logic        cnt_ok;                            // sector count is supported

   ////////////////////////////////////////////////////////////////////////////
   // character lookup with padding
   // right-justified field: leading positions blank, text at the tail
   function automatic logic [7:0] char_right(input logic [6:0] base, input logic [5:0] pos,
                                             input logic [5:0] len, input logic [5:0] size);
      logic [5:0] lead;
      lead = size - len;
      if (pos < lead) begin
         char_right = identify_pkg::BLANK;
      end else begin
         char_right = text_q[base + 7'(pos - lead)];
      end
   endfunction

   // left-justified field: text first, blank after
   function automatic logic [7:0] char_left(input logic [6:0] base, input logic [5:0] pos,
                                            input logic [5:0] len);
      if (pos < len) begin
         char_left = text_q[base + 7'(pos)];
      end else begin
         char_left = identify_pkg::BLANK;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // word composer for fill_idx_q
   always_comb begin
      logic [5:0] pos;                              // first char of this word
      pos    = 6'h00;
      word_d = 16'h0000;
      if (fill_idx_q >= identify_pkg::W_SER_FIRST && fill_idx_q <= identify_pkg::W_SER_LAST) begin
         pos    = 6'((fill_idx_q - identify_pkg::W_SER_FIRST) << 1);
         // earlier character in the high byte
         word_d = {char_right(identify_pkg::SER_BASE, pos, 6'(ser_len_q), 6'(identify_pkg::SER_CHARS)),
                   char_right(identify_pkg::SER_BASE, pos + 6'h01, 6'(ser_len_q),
                              6'(identify_pkg::SER_CHARS))};
      end else if (fill_idx_q >= identify_pkg::W_FW_FIRST && fill_idx_q <= identify_pkg::W_FW_LAST) begin
         pos    = 6'((fill_idx_q - identify_pkg::W_FW_FIRST) << 1);
         word_d = {char_left(identify_pkg::FW_BASE, pos, 6'(fw_len_q)),
                   char_left(identify_pkg::FW_BASE, pos + 6'h01, 6'(fw_len_q))};
      end else if (fill_idx_q >= identify_pkg::W_MOD_FIRST && fill_idx_q <= identify_pkg::W_MOD_LAST) begin
         pos    = 6'((fill_idx_q - identify_pkg::W_MOD_FIRST) << 1);
         word_d = {char_left(identify_pkg::MODEL_BASE, pos, model_len_q),
                   char_left(identify_pkg::MODEL_BASE, pos + 6'h01, model_len_q)};
      end else begin
         unique case (fill_idx_q)
            identify_pkg::W_CONFIG:  word_d = identify_pkg::V_CONFIG;
            identify_pkg::W_CAPS:    word_d = identify_pkg::V_CAPS;
            identify_pkg::W_PIO:     word_d = identify_pkg::V_PIO;
            identify_pkg::W_VALID:   word_d = identify_pkg::V_VALID;
            identify_pkg::W_MULTI:   word_d = {7'h00, multi_en_q, multi_cnt_q};
            identify_pkg::W_MWDMA:   word_d = {mwdma_cur_q, identify_pkg::V_MWDMA_SUP};
            identify_pkg::W_ADV_PIO: word_d = identify_pkg::V_ADV_PIO;
            identify_pkg::W_MAJOR:   word_d = identify_pkg::V_MAJOR;
            identify_pkg::W_SUP1:    word_d = identify_pkg::V_SUP1;
            identify_pkg::W_SUP2:    word_d = identify_pkg::V_SUP2;
            identify_pkg::W_ENA1:    word_d = identify_pkg::V_ENA1;
            identify_pkg::W_ENA2:    word_d = identify_pkg::V_ENA2;
            identify_pkg::W_UDMA:    word_d = {3'h0, udma_cur_q, 3'h0, identify_pkg::V_UDMA_SUP};
            identify_pkg::W_CABLE:   word_d = 16'(cable_q) << identify_pkg::CABLE_BIT;
            default:                 word_d = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command sequencing: busy while filling, drq until the last word is read
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         phase_q    <= IDLE;
         fill_idx_q <= 8'h00;
         rd_idx_q   <= 8'h00;
         busy       <= 1'b0;
         drq        <= 1'b0;
         intrq      <= 1'b0;
      end else begin
         unique case (phase_q)
            // a new command restarts only when no fill is running
            IDLE, SEND: begin
               if (ident_cmd) begin
                  phase_q    <= FILL;
                  fill_idx_q <= 8'h00;
                  busy       <= 1'b1;
                  drq        <= 1'b0;
                  intrq      <= 1'b0;
               end else if (phase_q == SEND && host_rd) begin
                  intrq    <= 1'b0;                   // first read acknowledges
                  rd_idx_q <= rd_idx_q + 8'h01;
                  if (rd_idx_q == identify_pkg::LAST_WORD) begin
                     phase_q <= IDLE;                 // page exhausted
                     drq     <= 1'b0;
                  end
               end
            end
            // one word per cycle into the buffer
            FILL: begin
               fill_idx_q <= fill_idx_q + 8'h01;
               if (fill_idx_q == identify_pkg::LAST_WORD) begin
                  phase_q  <= SEND;
                  rd_idx_q <= 8'h00;
                  busy     <= 1'b0;
                  drq      <= 1'b1;
                  intrq    <= 1'b1;
               end
            end
            default: phase_q <= IDLE;
         endcase
      end
   end

   // sector buffer write; no reset needed, every word is rewritten before use
   always_ff @(posedge core_clk) begin
      if (phase_q == FILL) begin
         page_q[fill_idx_q] <= word_d;
      end
   end

   // host data port; holds the last word between reads
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         host_data <= 16'h0000;
      end else if (phase_q == SEND && host_rd && !ident_cmd) begin
         host_data <= page_q[rd_idx_q];
      end
   end

   // cable level captured when the command arrives, so the page is consistent
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cable_q <= 1'b0;
      end else if (ident_cmd && phase_q != FILL) begin
         cable_q <= cable_det;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes
   assign cnt_ok = (reg_wdata[7:0] == 8'h02) || (reg_wdata[7:0] == 8'h04) ||
                   (reg_wdata[7:0] == 8'h08) || (reg_wdata[7:0] == 8'h10);

   // multiple-sector setting; unsupported counts leave the old count
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         multi_en_q  <= 1'b0;
         multi_cnt_q <= identify_pkg::MULTI_RESET;
      end else if (reg_wr && reg_addr == identify_pkg::REG_MULTI) begin
         multi_en_q <= reg_wdata[identify_pkg::MULTI_EN_BIT];
         if (cnt_ok) begin
            multi_cnt_q <= reg_wdata[7:0];
         end
      end
   end

   // modes in use and string lengths
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mwdma_cur_q <= 8'h00;
         udma_cur_q  <= 5'h00;
         ser_len_q   <= 5'h00;
         fw_len_q    <= 4'h0;
         model_len_q <= 6'h00;
      end else if (reg_wr) begin
         if (reg_addr == identify_pkg::REG_MODE) begin
            mwdma_cur_q <= reg_wdata[7:0];
            udma_cur_q  <= reg_wdata[12:8];
         end
         if (reg_addr == identify_pkg::REG_LEN) begin
            // lengths beyond a field saturate so padding never goes negative
            ser_len_q   <= (reg_wdata[4:0] > 5'(identify_pkg::SER_CHARS)) ?
                           5'(identify_pkg::SER_CHARS) : reg_wdata[4:0];
            fw_len_q    <= (reg_wdata[11:8] > 4'(identify_pkg::FW_CHARS)) ?
                           4'(identify_pkg::FW_CHARS) : reg_wdata[11:8];
            model_len_q <= (reg_wdata[21:16] > 6'(identify_pkg::MODEL_CHARS)) ?
                           6'(identify_pkg::MODEL_CHARS) : reg_wdata[21:16];
         end
      end
   end

   // character store; out-of-range indices are dropped
   always_ff @(posedge core_clk) begin
      if (reg_wr && reg_addr == identify_pkg::REG_CHAR &&
          reg_wdata[14:8] < 7'(identify_pkg::TEXT_CHARS)) begin
         text_q[reg_wdata[14:8]] <= reg_wdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register reads, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            identify_pkg::REG_MULTI:  reg_rdata <= {23'h0, multi_en_q, multi_cnt_q};
            identify_pkg::REG_MODE:   reg_rdata <= {19'h0, udma_cur_q, mwdma_cur_q};
            identify_pkg::REG_LEN:    reg_rdata <= {10'h0, model_len_q, 4'h0, fw_len_q,
                                                    3'h0, ser_len_q};
            identify_pkg::REG_STATUS: reg_rdata <= {16'h0, rd_idx_q, 6'h0, drq, busy};
            default:                  reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

endmodule

/* File: rtl/identify_pkg.sv */
/*
 * identify_pkg: constants shared by the identification page composer:
 * page geometry, word indices, fixed word values, field positions, register offsets.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package identify_pkg;
   // page geometry
   localparam int unsigned PAGE_WORDS  = 256;     // 512-byte page
   localparam int unsigned IDX_W       = 8;       // word index width
   localparam logic [7:0]  LAST_WORD   = 8'hFF;   // final word of the page
   // string fields, in characters
   localparam int unsigned SER_CHARS   = 20;
   localparam int unsigned FW_CHARS    = 8;
   localparam int unsigned MODEL_CHARS = 40;
   localparam int unsigned TEXT_CHARS  = 68;      // serial, firmware, model back to back
   localparam logic [6:0]  SER_BASE    = 7'h00;   // char store base of each field
   localparam logic [6:0]  FW_BASE     = 7'h14;
   localparam logic [6:0]  MODEL_BASE  = 7'h1C;
   localparam logic [7:0]  BLANK       = 8'h20;   // padding code
   // word indices
   localparam logic [7:0]  W_CONFIG    = 8'h00;
   localparam logic [7:0]  W_SER_FIRST = 8'h0A;
   localparam logic [7:0]  W_SER_LAST  = 8'h13;
   localparam logic [7:0]  W_FW_FIRST  = 8'h17;
   localparam logic [7:0]  W_FW_LAST   = 8'h1A;
   localparam logic [7:0]  W_MOD_FIRST = 8'h1B;
   localparam logic [7:0]  W_MOD_LAST  = 8'h2E;
   localparam logic [7:0]  W_CAPS      = 8'h31;
   localparam logic [7:0]  W_PIO       = 8'h33;
   localparam logic [7:0]  W_VALID     = 8'h35;
   localparam logic [7:0]  W_MULTI     = 8'h3B;
   localparam logic [7:0]  W_MWDMA     = 8'h3F;
   localparam logic [7:0]  W_ADV_PIO   = 8'h40;
   localparam logic [7:0]  W_MAJOR     = 8'h50;
   localparam logic [7:0]  W_SUP1      = 8'h52;
   localparam logic [7:0]  W_SUP2      = 8'h53;
   localparam logic [7:0]  W_ENA1      = 8'h55;
   localparam logic [7:0]  W_ENA2      = 8'h56;
   localparam logic [7:0]  W_UDMA      = 8'h58;
   localparam logic [7:0]  W_CABLE     = 8'h5D;
   // fixed word values
   localparam logic [15:0] V_CONFIG    = 16'h0040;  // ata, fixed, non-removable
   localparam logic [15:0] V_CAPS      = 16'h0B00;  // iordy, lba, dma
   localparam logic [15:0] V_PIO       = 16'h0200;  // pio mode 2
   localparam logic [15:0] V_VALID     = 16'h0007;
   localparam logic [7:0]  V_MWDMA_SUP = 8'h07;     // modes 2..0
   localparam logic [15:0] V_ADV_PIO   = 16'h0003;  // modes 4 and 3
   localparam logic [15:0] V_MAJOR     = 16'h001E;  // ata-1..4
   localparam logic [15:0] V_SUP1      = 16'h3469;
   localparam logic [15:0] V_SUP2      = 16'h4008;
   localparam logic [15:0] V_ENA1      = 16'h0061;
   localparam logic [15:0] V_ENA2      = 16'h0008;
   localparam logic [4:0]  V_UDMA_SUP  = 5'h1F;     // modes 4..0
   localparam int unsigned CABLE_BIT   = 13;
   // register offsets
   localparam logic [7:0]  REG_MULTI   = 8'h00;  // [8] enable, [7:0] sectors
   localparam logic [7:0]  REG_MODE    = 8'h04;  // [7:0] mwdma in use, [12:8] udma in use
   localparam logic [7:0]  REG_LEN     = 8'h08;  // [4:0] serial, [11:8] fw, [21:16] model
   localparam logic [7:0]  REG_CHAR    = 8'h0C;  // [14:8] char index, [7:0] code
   localparam logic [7:0]  REG_STATUS  = 8'h10;  // [0] busy, [1] drq, [15:8] word index
   localparam int unsigned MULTI_EN_BIT = 8;
   localparam logic [7:0]  MULTI_RESET = 8'h10;
endpackage

/* File: verification/identify_data_composer_checker.sv */
/*
 * identify_data_composer_checker: command timing and page word assertions.
 * assumes: one clock domain; the host reads only while drq is high.
 */
module identify_data_composer_checker (
   input wire logic        core_clk,   // clock
   input wire logic        rst,        // async reset, active high
   input wire logic        ident_cmd,  // command pulse
   input wire logic        host_rd,    // host read pulse
   input wire logic [15:0] host_data,  // page word
   input wire logic        busy,       // composing
   input wire logic        drq,        // page ready
   input wire logic        intrq       // interrupt level
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   logic [8:0] idx_q;  // reads taken since the page was composed
   // index of the next word; cleared while composing so a restart begins at 0
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         idx_q <= 9'h000;
      end else if (busy) begin
         idx_q <= 9'h000;
      end else if (host_rd && drq) begin
         idx_q <= idx_q + 9'h001;
      end
   end
   // word n, masked to the bits that are fixed, arrives the cycle after its read
   property p_word(logic [8:0] n, logic [15:0] m, logic [15:0] v);
      host_rd && drq && idx_q == n |=> (host_data & m) == v;
   endproperty
   ////////////////////////////////////////////////////////////////////////////////
   a_cmd_busy: assert property (ident_cmd && !busy |=> busy)
      else $error("command did not raise busy");
   a_fill_time: assert property ($rose(busy) |-> ##255 busy ##1 (!busy && drq && intrq))
      else $error("page fill did not end after 256 cycles");
   a_intrq_clear: assert property (intrq && host_rd |=> !intrq)
      else $error("interrupt not cleared by first read");
   a_intrq_drq: assert property (intrq |-> drq && !busy)
      else $error("interrupt without ready page");
   a_drq_hold: assert property (drq && !ident_cmd && !(host_rd && idx_q == 9'h0FF) |=> drq)
      else $error("data request dropped early");
   a_drq_end: assert property (drq && host_rd && idx_q == 9'h0FF |=> !drq && !busy)
      else $error("data request held past last word");
   a_word_cfg: assert property (p_word(9'h000, 16'h80C1, 16'h0040))
      else $error("config word wrong");
   a_word_caps: assert property (p_word(9'h031, 16'h2F00, 16'h0B00))
      else $error("capabilities word wrong");
   a_word_pio: assert property (p_word(9'h033, 16'hFF00, 16'h0200))
      else $error("pio mode word wrong");
   a_word_valid: assert property (p_word(9'h035, 16'h0007, 16'h0007))
      else $error("validity word wrong");
   a_adv_pio: assert property (p_word(9'h040, 16'h00FF, 16'h0003))
      else $error("advanced pio word wrong");
   a_word_major: assert property (p_word(9'h050, 16'h001E, 16'h001E))
      else $error("major version word wrong");
   a_word_support: assert property (p_word(9'h052, 16'hFFFF, 16'h3469))
      else $error("support word wrong");
   a_word_feature: assert property (p_word(9'h053, 16'hC01F, 16'h4008))
      else $error("feature support word wrong");
   a_word_enabled: assert property (p_word(9'h055, 16'hFFFF, 16'h0061))
      else $error("enabled word wrong");
   a_word_apm: assert property (p_word(9'h056, 16'h001F, 16'h0008))
      else $error("apm enabled word wrong");
   // main scenarios reached
   c_page_ready: cover property ($rose(drq));
   c_cmd_in_fill: cover property (ident_cmd && busy);
   c_cmd_in_send: cover property (ident_cmd && drq);
endmodule

bind identify_data_composer identify_data_composer_checker i_identify_data_composer_checker (
   .core_clk(core_clk), .rst(rst), .ident_cmd(ident_cmd), .host_rd(host_rd),
   .host_data(host_data), .busy(busy), .drq(drq), .intrq(intrq));

/* File: verification/ata_host_model.sv */
/*
 * ata_host_model: host side of the page data port, reads one page into mem.
 * assumes: host_data appears the cycle after host_rd; arm high holds it idle.
 */
module ata_host_model (
   input  wire logic        core_clk,   // clock
   input  wire logic        rst,        // async reset, active high
   input  wire logic        arm,        // high: idle and cleared
   input  wire logic        slow,       // leave a gap after each read
   input  wire logic        drq,        // page ready
   input  wire logic [15:0] host_data,  // word from device
   output logic             host_rd,    // read pulse
   output logic      [8:0]  n_got       // words captured
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [256];  // captured page
   logic [8:0]  n_req;      // reads issued
   logic        pend;       // a word lands this cycle
   ////////////////////////////////////////////////////////////////////////////////
   // reads only while drq, and never past one page, since n_req stops new reads at 256
   always @(posedge core_clk or posedge rst) begin
      if (rst || arm) begin
         host_rd <= 1'b0;
         n_req   <= 9'h000;
         n_got   <= 9'h000;
         pend    <= 1'b0;
      end else begin
         pend <= host_rd;
         if (pend) begin  // word of the previous read
            mem[n_got[7:0]] <= host_data;
            n_got           <= n_got + 9'h001;
         end
         n_req   <= n_req + {8'h00, host_rd};
         host_rd <= drq && (n_req + {8'h00, host_rd} < 9'h100) && !(slow && host_rd);
      end
   end
endmodule

/* File: verification/tb_identify_data_composer.sv */
/*
 * tb_identify_data_composer: register setup, page composition and readback.
 * assumes: the checker is bound to the design; host model reads the page.
 */
module tb_identify_data_composer;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {logic [31:0] multi, mode, len; logic cab; logic [15:0] w59; int sl, fl, ml;} row_t;
   logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ident_cmd = 1'b0;
   logic cable_det = 1'b0, arm = 1'b1, slow = 1'b0, host_rd, busy, drq, intrq;
   logic [7:0]  reg_addr = 8'h00;   // register address
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [15:0] host_data, w59;     // page word, expected word 59
   logic [12:0] md;                 // expected modes in use
   logic [8:0]  n_got;              // words the host captured
   int errors = 0, n_compared = 0, sl, fl, ml;
   // ordinary cases: settings beside the word 59 and string lengths they give
   row_t rows [5] = '{'{32'h108, 32'h1004, 32'h90305, 1'b1, 16'h0108, 5, 3, 9},
      '{32'h2, 32'h101, 32'h280814, 1'b0, 16'h0002, 20, 8, 40},
      '{32'h104, 32'h802, 32'h0, 1'b1, 16'h0104, 0, 0, 0},
      '{32'h110, 32'h201, 32'h3F0F1F, 1'b0, 16'h0110, 20, 8, 40},   // lengths saturate
      '{32'h5, 32'h0, 32'h10101, 1'b1, 16'h0010, 1, 1, 1}};          // count 5 refused
   always #2.5 core_clk = ~core_clk;
   identify_data_composer i_identify_data_composer (.core_clk(core_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ident_cmd(ident_cmd), .cable_det(cable_det), .host_rd(host_rd),
      .host_data(host_data), .busy(busy), .drq(drq), .intrq(intrq));
   ata_host_model i_ata_host_model (.core_clk(core_clk), .rst(rst), .arm(arm), .slow(slow),
      .drq(drq), .host_data(host_data), .host_rd(host_rd), .n_got(n_got));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 check(s, reg_rdata, e);
   endtask
   // character on the page: serial right-justified, firmware and model left, blank padded
   function automatic logic [7:0] chr(int p);
      if (p < 20) return (p >= 20 - sl) ? 8'(65 + p - 20 + sl) : 8'h20;
      if (p < 28) return (p - 20 < fl) ? 8'(65 + p) : 8'h20;
      return (p - 28 < ml) ? 8'(65 + p) : 8'h20;
   endfunction
   function automatic logic [15:0] exp_word(int w);
      if (w >= 10 && w <= 19) return {chr(2 * w - 20), chr(2 * w - 19)};
      if (w >= 23 && w <= 46) return {chr(2 * w - 26), chr(2 * w - 25)};
      case (w)
         0: return 16'h0040;
         49: return 16'h0B00;
         51: return 16'h0200;
         53: return 16'h0007;
         59: return w59;
         63: return {md[7:0], 8'h07};
         64: return 16'h0003;
         80: return 16'h001E;
         82: return 16'h3469;
         83: return 16'h4008;
         85: return 16'h0061;
         86: return 16'h0008;
         88: return {3'h0, md[12:8], 8'h1F};
         93: return {2'h0, cable_det, 13'h0000};
         default: return 16'h0000;  // undefined words
      endcase
   endfunction
   // command pulse, optionally repeated mid-fill; counts edges until drq
   task automatic cmd(input bit dup);
      int n;
      n = 1;
      @(posedge core_clk);
      ident_cmd <= 1'b1;
      @(posedge core_clk);
      ident_cmd <= 1'b0;
      do begin
         @(posedge core_clk);
         if (dup) ident_cmd <= (n == 10);
         n++;
         #1;
      end while (!drq && n < 400);
      check("fill cycles", n, 257);
      check("flags at ready", {busy, drq, intrq}, 3'h3);
   endtask
   task automatic run_page(input row_t r, input bit restart);
      wr(identify_pkg::REG_MULTI, r.multi);
      wr(identify_pkg::REG_MODE, r.mode);
      wr(identify_pkg::REG_LEN, r.len);
      rd(identify_pkg::REG_MULTI, {16'h0, r.w59}, "multi readback");
      {sl, fl, ml, md, w59} = {r.sl, r.fl, r.ml, r.mode[12:0], r.w59};
      cable_det <= r.cab;
      slow      <= r.cab;
      cmd(1'b0);
      if (restart) begin  // partial read, then a new command mid-page
         arm <= 1'b0;
         repeat (6) @(posedge core_clk);
         arm       <= 1'b1;
         cable_det <= !r.cab;
         #1 check("intrq after read", intrq, 1'b0);
         cmd(1'b1);
      end
      arm <= 1'b0;
      for (int k = 0; k < 1000 && n_got !== 9'h100; k++) @(posedge core_clk) #1;
      for (int w = 0; w < 256; w++)
         check($sformatf("word %0d", w), i_ata_host_model.mem[w], exp_word(w));
      check("flags at end", {busy, drq, intrq, n_got}, {3'h0, 9'h100});
      @(posedge core_clk);
      arm <= 1'b1;
      $display("page test done, restart %0d", restart);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: the whole sequence needs well under 20000 cycles
   initial begin
      #100000;
      errors++;
      $display("watchdog expired");
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      #1 check("flags after reset", {busy, drq, intrq}, 3'h0);
      rd(identify_pkg::REG_MULTI, 32'h10, "multi reset");
      rd(identify_pkg::REG_MODE, 32'h0, "mode reset");
      rd(identify_pkg::REG_LEN, 32'h0, "length reset");
      wr(identify_pkg::REG_STATUS, 32'hFFFFFFFF);
      rd(identify_pkg::REG_STATUS, 32'h0, "status read-only");
      rd(8'h20, 32'h0, "unmapped read");
      for (int i = 0; i < 68; i++) wr(identify_pkg::REG_CHAR, {17'h0, 7'(i), 8'(65 + i)});
      wr(identify_pkg::REG_CHAR, {17'h0, 7'h44, 8'h7E});  // out of range, must not alias
      rd(identify_pkg::REG_CHAR, 32'h0, "char readback");
      $display("register test done");
      foreach (rows[i]) run_page(rows[i], 1'b0);
      run_page(rows[0], 1'b1);
      // mid-fill reset: flags and settings must fall back to their reset values
      ident_cmd <= 1'b1;
      @(posedge core_clk);
      ident_cmd <= 1'b0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      #1 check("flags after second reset", {busy, drq, intrq}, 3'h0);
      rd(identify_pkg::REG_MULTI, 32'h10, "multi after reset");
      $display("mid-fill reset test done");
      end_of_test();
   end
endmodule
